// >>> verilog/card_interface_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Card clock is reference clock divided 1/2/4/8.
// [RULE2] Select 00=/8, 01=/4, 11=/2, 10=/1.
// [RULE3] Voltage select high gives 5V, low 3V.
// [RULE4] Low-voltage select forces 1.8V operation.
// [RULE5] Two presence inputs, active low and high.
// [RULE6] Status follows presence after 8ms debounce.
// [RULE7] Session request low starts activation.
// [RULE8] Status output is active-low, pulled up.
// [RULE9] Hold inactive until supply valid plus pulse.
// [RULE10] Supply drop runs the deactivation sequence.
// [RULE11] Low-idle variant needs external reference clock.
// [RULE12] Activation: data at 4T, clock/reset at 7T.
// [RULE13] Deactivation: reset, clock, data, supply stepwise.
// [RULE14] Stop mode when request and selects high.
// [RULE15] Host keeps voltage selects stable during session.
module card_interface_ctrl
  import card_ctrl_pkg::*;
#(
  parameter int POR_CYCLES = POR_PULSE_CYCLES,
  parameter int DEBOUNCE_TIME_CYCLES = DEBOUNCE_CYCLES
) (
  input wire logic hclk, // System clock, 100 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire logic reference_clock_input, // Reference clock level, sampled.
  input wire logic clock_divider_select_a, // Divider select, first bit.
  input wire logic clock_divider_select_b, // Divider select, second bit.
  input wire logic card_voltage_select, // High 5V, low 3V.
  input wire logic low_voltage_card_select, // High forces 1.8V.
  input wire logic session_request_n, // Session request, active low.
  input wire logic host_card_reset, // Host card reset level.
  input wire logic presence_low_n, // Card presence, active low.
  input wire logic presence_high, // Card presence, active high.
  input wire logic supply_valid, // Host supply monitor, high when valid.
  output logic card_clock, // Card clock.
  output logic card_reset, // Card reset.
  output logic card_vcc_enable, // Card supply on.
  output logic [1:0] card_vcc_level, // Card supply level code.
  output logic data_line_enable, // Card data lines enabled, else pulled low.
  output logic osc_fast, // Sequencer oscillator at high rate.
  output logic stop_mode, // Stop mode.
  output logic status_out, // Status pin drive level, always low.
  output logic status_oe // Status pin drive enable, high when asserted.
);

  generate
    if (POR_CYCLES < 1 || POR_CYCLES >= (1 << POR_W)) begin : g_bad_por
      $error("POR_CYCLES out of range");
    end
    if (DEBOUNCE_TIME_CYCLES < 1 || DEBOUNCE_TIME_CYCLES >= (1 << DEB_W)) begin : g_bad_deb
      $error("DEBOUNCE_TIME_CYCLES out of range");
    end
  endgenerate

  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);
  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_TIME_CYCLES - 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(HALF_T_CYCLES - 1);

  typedef struct packed {
    seq_state_type state;
    logic [POR_W-1:0] por_count;
    logic ready;
    logic [DEB_W-1:0] deb_count;
    logic present;
    logic [TICK_W-1:0] tick;
    logic [4:0] phase;
    logic [1:0] vlevel;
    logic fault;
    logic clk_early;
    logic [1:0] control;
    logic bus_write;
    logic [7:0] bus_addr;
    logic [31:0] rdata;
  } ctrl_state_type;

  ctrl_state_type r_reg;
  ctrl_state_type r_next;
  card_clock_if clk_link ();

  logic raw_present;
  logic in_act;
  logic in_active;
  logic in_deact;
  logic stop_now;
  logic leave;
  logic addr_phase;

  // Word match on the low address byte, used by both read and write paths.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
    reg_hit = (addr[7:2] == target[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded state.

  assign raw_present = !presence_low_n || presence_high; // [RULE5]
  assign in_act = (r_reg.state == ST_ACTIVATE);
  assign in_active = (r_reg.state == ST_ACTIVE);
  assign in_deact = (r_reg.state == ST_DEACTIVATE);
  assign stop_now = session_request_n && card_voltage_select && low_voltage_card_select; // [RULE14]
  assign leave = session_request_n || !supply_valid || !r_reg.present || r_reg.control[CTRL_FORCE_OFF_BIT];
  assign addr_phase = hsel && htrans[1] && hready;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Power-on hold, debounce, sequencer and register file.
  always_comb begin
    r_next = r_reg;
    // Supply monitor and internal reset pulse.
    if (!supply_valid) begin
      r_next.por_count = '0;
      r_next.ready = 1'b0; // [RULE9]
    end else if (!r_reg.ready) begin
      if (r_reg.por_count == POR_LAST) begin
        r_next.ready = 1'b1; // [RULE9]
      end else begin
        r_next.por_count = r_reg.por_count + 1'b1;
      end
    end
    // Presence debounce: a change must persist for the whole time.
    if (raw_present == r_reg.present) begin
      r_next.deb_count = '0;
    end else if (r_reg.deb_count == DEB_LAST) begin
      r_next.deb_count = '0;
      r_next.present = raw_present; // [RULE6]
    end else begin
      r_next.deb_count = r_reg.deb_count + 1'b1;
    end
    // Half-T timebase runs only inside the sequences.
    if (in_act || in_deact) begin
      if (r_reg.tick == TICK_LAST) begin
        r_next.tick = '0;
        r_next.phase = r_reg.phase + 5'h1;
      end else begin
        r_next.tick = r_reg.tick + 1'b1;
      end
    end
    if (in_act && r_reg.phase >= ACT_DATA_HALVES && !host_card_reset) begin
      r_next.clk_early = 1'b1;
    end
    case (r_reg.state)
      ST_HOLD: begin
        if (r_reg.ready) begin
          r_next.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        r_next.clk_early = 1'b0;
        if (!r_reg.ready) begin
          r_next.state = ST_HOLD; // [RULE9]
        end else if (!session_request_n && r_reg.present && r_reg.control[CTRL_ENABLE_BIT]) begin // [RULE7]
          r_next.state = ST_ACTIVATE;
          r_next.tick = '0;
          r_next.phase = 5'h0;
          r_next.fault = 1'b0;
          // Level is taken once here and held for the session. [RULE15]
          r_next.vlevel = low_voltage_card_select ? VCC_1V8 : (card_voltage_select ? VCC_5V : VCC_3V); // [RULE3] [RULE4]
        end
      end
      ST_ACTIVATE, ST_ACTIVE: begin
        if (leave) begin
          r_next.state = ST_DEACTIVATE; // [RULE10] [RULE13]
          r_next.tick = '0;
          r_next.phase = 5'h0;
          r_next.fault = !r_reg.present;
        end else if (in_act && r_reg.phase == ACT_RESET_HALVES) begin
          r_next.state = ST_ACTIVE; // [RULE12]
        end
      end
      ST_DEACTIVATE: begin
        if (r_reg.phase == DEACT_DONE_HALVES) begin
          r_next.state = ST_IDLE;
        end
      end
      default: r_next.state = ST_HOLD;
    endcase
    // Bus: address phase captured, write applied in the data phase.
    r_next.bus_write = addr_phase && hwrite;
    if (addr_phase) begin
      r_next.bus_addr = haddr[7:0];
    end
    if (r_reg.bus_write && reg_hit(r_reg.bus_addr, CONTROL_ADDR)) begin
      r_next.control = hwdata[1:0];
    end
    if (addr_phase && !hwrite) begin
      r_next.rdata = 32'h0;
      if (reg_hit(haddr[7:0], CONTROL_ADDR)) begin
        r_next.rdata[1:0] = r_reg.control;
      end else if (reg_hit(haddr[7:0], STATUS_ADDR)) begin
        r_next.rdata[ST_STATE_LSB +: 3] = r_reg.state;
        r_next.rdata[ST_PRESENT_BIT] = r_reg.present;
        r_next.rdata[ST_FAULT_BIT] = r_reg.fault;
        r_next.rdata[ST_VCC_LSB +: 2] = r_reg.vlevel;
        r_next.rdata[ST_READY_BIT] = r_reg.ready;
        r_next.rdata[ST_STOP_BIT] = stop_mode;
        r_next.rdata[ST_PHASE_LSB +: 5] = r_reg.phase;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // All state advances only while the clock enable is high.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.state <= ST_HOLD;
      r_reg.control <= CONTROL_RESET;
      r_reg.vlevel <= VCC_3V;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Card side outputs.

  // Clock runs from 7T, or from 4T once the host holds card reset low, until 0.5T into deactivation.
  assign clk_link.run = in_active || (in_act && (r_reg.phase == ACT_RESET_HALVES || r_reg.clk_early))
                        || (in_deact && r_reg.phase < DEACT_CLK_HALVES); // [RULE12] [RULE13]
  assign clk_link.divide_sel = {clock_divider_select_a, clock_divider_select_b};
  assign clk_link.ref_level = reference_clock_input;

  card_clock_divider u_divider (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .link(clk_link.divider)
  );

  // Contacts stay low outside a session, which also covers the power-on hold.
  assign card_clock = clk_link.card_clock; // [RULE1]
  assign card_reset = in_active && host_card_reset; // [RULE12] [RULE13]
  assign card_vcc_enable = in_act || in_active || (in_deact && r_reg.phase < DEACT_VCC_HALVES); // [RULE13]
  assign card_vcc_level = r_reg.vlevel;
  assign data_line_enable = (in_act && r_reg.phase >= ACT_DATA_HALVES) || in_active
                            || (in_deact && r_reg.phase < DEACT_DATA_HALVES); // [RULE12] [RULE13]
  assign osc_fast = in_act || in_active || in_deact; // [RULE12]
  assign stop_mode = stop_now && (r_reg.state == ST_IDLE || r_reg.state == ST_HOLD); // [RULE14]

  ////////////////////////////////////////////////////////////////////////////////
  // Host side outputs.

  // Open-drain status: pulled low for no card or a session lost to card removal.
  assign status_out = 1'b0;
  assign status_oe = !r_reg.present || r_reg.fault; // [RULE6] [RULE8]
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdata;

endmodule

// >>> verilog/card_ctrl_pkg.sv
package card_ctrl_pkg;

  // Clock and timing figures.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEQ_T_NS = 25000;           // One sequencer unit T, 64 slow oscillator periods.
  localparam int HALF_T_CYCLES = SEQ_T_NS / CLK_PERIOD_NS / 2;
  localparam int DEBOUNCE_MS = 8;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POR_PULSE_US = 220;
  localparam int POR_PULSE_CYCLES = POR_PULSE_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_W = 11;
  localparam int DEB_W = 20;
  localparam int POR_W = 16;

  // Sequencer milestones counted in half units of T.
  localparam logic [4:0] ACT_VCC_UP_HALVES = 5'h03;
  localparam logic [4:0] ACT_DATA_HALVES = 5'h08;
  localparam logic [4:0] ACT_RESET_HALVES = 5'h0e;
  localparam logic [4:0] DEACT_CLK_HALVES = 5'h01;
  localparam logic [4:0] DEACT_DATA_HALVES = 5'h02;
  localparam logic [4:0] DEACT_VCC_HALVES = 5'h03;
  localparam logic [4:0] DEACT_DONE_HALVES = 5'h04;

  // Card supply level codes.
  localparam logic [1:0] VCC_3V = 2'h0;
  localparam logic [1:0] VCC_5V = 2'h1;
  localparam logic [1:0] VCC_1V8 = 2'h2;

  // Register map, byte addresses, and reset values.
  localparam logic [7:0] CONTROL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORCE_OFF_BIT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h1;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PRESENT_BIT = 3;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_VCC_LSB = 5;
  localparam int ST_READY_BIT = 7;
  localparam int ST_STOP_BIT = 8;
  localparam int ST_PHASE_LSB = 9;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_IDLE = 3'b001,
    ST_ACTIVATE = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_DEACTIVATE = 3'b100
  } seq_state_type;

endpackage

// >>> verilog/card_clock_if.sv
`timescale 1ns/1ps
interface card_clock_if;
  logic [1:0] divide_sel;
  logic ref_level;
  logic run;
  logic card_clock;
  modport control (output divide_sel, output ref_level, output run, input card_clock);
  modport divider (input divide_sel, input ref_level, input run, output card_clock);
endinterface

// >>> verilog/card_clock_divider.sv
`timescale 1ns/1ps
module card_clock_divider (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  card_clock_if.divider link // Select, reference level and run request in, card clock out.
);

  typedef struct packed {
    logic ref_prev;
    logic [2:0] count;
    logic clk;
  } div_state_type;

  div_state_type r_reg;
  div_state_type r_next;

  // Reference edges to wait between card clock toggles: 8, 4, 2 or 1, so 4, 2, 1 or half a reference period.
  function automatic logic [2:0] toggle_limit(input logic [1:0] sel);
    case (sel)
      2'b00: toggle_limit = 3'h7;
      2'b01: toggle_limit = 3'h3;
      2'b11: toggle_limit = 3'h1;
      2'b10: toggle_limit = 3'h0;
      default: toggle_limit = 3'h7;
    endcase
  endfunction

  // Toggling only on reference edges keeps every half period whole when the select changes.
  always_comb begin
    r_next = r_reg;
    r_next.ref_prev = link.ref_level;
    if (!link.run) begin
      r_next.count = 3'h0;
      r_next.clk = 1'b0;
    end else if (link.ref_level != r_reg.ref_prev) begin
      if (r_reg.count >= toggle_limit(link.divide_sel)) begin // [RULE1] [RULE2]
        r_next.count = 3'h0;
        r_next.clk = ~r_reg.clk;
      end else begin
        r_next.count = r_reg.count + 3'h1;
      end
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign link.card_clock = r_reg.clk;

endmodule

// >>> sim/card_interface_ctrl_monitor.sv
`timescale 1ns/1ps
module card_interface_ctrl_monitor
  import card_ctrl_pkg::*;
#(
  parameter int POR_CYCLES = 4,
  parameter int DEBOUNCE_TIME_CYCLES = 8
) (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset, active low.
  input wire logic session_request_n, // Session request.
  input wire logic card_voltage_select, // 5V or 3V.
  input wire logic low_voltage_card_select, // 1.8V override.
  input wire logic presence_low_n, // Presence, active low.
  input wire logic presence_high, // Presence, active high.
  input wire logic supply_valid, // Supply good.
  input wire logic card_clock, // Card clock.
  input wire logic card_reset, // Card reset.
  input wire logic card_vcc_enable, // Card supply on.
  input wire logic [1:0] card_vcc_level, // Supply level.
  input wire logic data_line_enable, // Data lines on.
  input wire logic osc_fast, // Fast oscillator.
  input wire logic stop_mode, // Stop mode.
  input wire logic status_out, // Status level.
  input wire logic status_oe // Status drive.
);
  logic [31:0] present_run_reg;
  logic [31:0] present_run_next;
  logic stop_cond;
  logic [31:0] drop_count_reg;
  logic [31:0] drop_count_next;
  // Longest time the card may stay powered after the host supply drops: 1.5T plus a small margin.
  localparam int DROP_LIMIT = int'(DEACT_VCC_HALVES) * HALF_T_CYCLES + 4;
  default clocking mon_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Counts how long a card has been seen without a break.
  always_comb present_run_next = (!presence_low_n || presence_high) ? present_run_reg + 32'h1 : 32'h0;
  // Counts how long the card stays powered while the host supply is low.
  always_comb drop_count_next = (!supply_valid && card_vcc_enable) ? drop_count_reg + 32'h1 : 32'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      present_run_reg <= 32'h0;
      drop_count_reg <= 32'h0;
    end else begin
      present_run_reg <= present_run_next;
      drop_count_reg <= drop_count_next;
    end
  end
  // Input pattern that asks for stop mode.
  assign stop_cond = session_request_n && card_voltage_select && low_voltage_card_select;
  ////////////////////////////////////////////////////////////
  a_status_low_drive: assert property (status_out == 1'b0) else $error("status pin not driven low");
  a_level_decode: assert property ($rose(card_vcc_enable) |-> card_vcc_level == (low_voltage_card_select ?
    VCC_1V8 : (card_voltage_select ? VCC_5V : VCC_3V))) else $error("card supply level wrong");
  a_request_start: assert property ($rose(osc_fast) |-> !$past(session_request_n))
    else $error("activation without request");
  a_drop_deact: assert property (drop_count_reg <= 32'(DROP_LIMIT))
    else $error("supply drop left card powered");
  a_release_reset: assert property ($rose(session_request_n) && card_reset |-> ##[1:2] !card_reset)
    else $error("card reset not dropped");
  a_contacts_idle: assert property (!card_vcc_enable |-> !card_clock && !data_line_enable && !card_reset)
    else $error("contacts active without supply");
  a_data_first: assert property ($rose(card_clock) |-> data_line_enable) else $error("clock before data");
  a_stop_decode: assert property (stop_mode |-> stop_cond || $past(stop_cond))
    else $error("stop mode without its inputs");
  a_debounce_wait: assert property ($fell(status_oe) |-> present_run_reg >= 32'(DEBOUNCE_TIME_CYCLES - 2))
    else $error("status released too early");
endmodule

bind card_interface_ctrl card_interface_ctrl_monitor #(.POR_CYCLES(POR_CYCLES),
  .DEBOUNCE_TIME_CYCLES(DEBOUNCE_TIME_CYCLES)) mon_u (.hclk(hclk), .hresetn(hresetn),
  .session_request_n(session_request_n), .card_voltage_select(card_voltage_select),
  .low_voltage_card_select(low_voltage_card_select), .presence_low_n(presence_low_n),
  .presence_high(presence_high), .supply_valid(supply_valid), .card_clock(card_clock), .card_reset(card_reset),
  .card_vcc_enable(card_vcc_enable), .card_vcc_level(card_vcc_level), .data_line_enable(data_line_enable),
  .osc_fast(osc_fast), .stop_mode(stop_mode), .status_out(status_out), .status_oe(status_oe));

// >>> sim/card_host_model.sv
`timescale 1ns/1ps
module card_host_model (
  input wire logic hclk, // System clock.
  input wire logic insert_low, // Card on the active-low switch.
  input wire logic insert_high, // Card on the active-high switch.
  output logic reference_clock_input, // Free-running reference clock.
  output logic presence_low_n, // Presence switch, active low.
  output logic presence_high // Presence switch, active high.
);
  logic [1:0] div_reg;
  initial div_reg = 2'h0;
  initial reference_clock_input = 1'b0;
  // External reference clock, one level every three system cycles.
  always @(posedge hclk) begin
    div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    if (div_reg == 2'h2) reference_clock_input <= !reference_clock_input;
  end
  // The two switches of the card slot.
  assign presence_low_n = !insert_low;
  assign presence_high = insert_high;
endmodule

// >>> sim/card_interface_ctrl_tb.sv
`timescale 1ns/1ps
module card_interface_ctrl_tb;
  import card_ctrl_pkg::*;
  localparam int DEB = 8;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, card_vcc_level;
  logic div_a = 1'b0, div_b = 1'b0, vsel = 1'b0, lvsel = 1'b0, req_n = 1'b1, host_rst = 1'b1;
  logic supply_valid = 1'b0, insert_low = 1'b0, insert_high = 1'b0, ref_clk, pres_n, pres_h;
  logic card_clock, card_reset, vcc_en, data_en, osc_fast, stop_mode, status_out, status_oe, prev;
  int n_errors = 0, checks_done = 0, cycles = 0;
  always #5 hclk = ~hclk;
  card_interface_ctrl #(.POR_CYCLES(4), .DEBOUNCE_TIME_CYCLES(DEB)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reference_clock_input(ref_clk),
    .clock_divider_select_a(div_a), .clock_divider_select_b(div_b), .card_voltage_select(vsel),
    .low_voltage_card_select(lvsel), .session_request_n(req_n), .host_card_reset(host_rst),
    .presence_low_n(pres_n), .presence_high(pres_h), .supply_valid(supply_valid), .card_clock(card_clock),
    .card_reset(card_reset), .card_vcc_enable(vcc_en), .card_vcc_level(card_vcc_level),
    .data_line_enable(data_en), .osc_fast(osc_fast), .stop_mode(stop_mode), .status_out(status_out),
    .status_oe(status_oe));
  card_host_model model_u (.hclk(hclk), .insert_low(insert_low), .insert_high(insert_high),
    .reference_clock_input(ref_clk), .presence_low_n(pres_n), .presence_high(pres_h));
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single-word bus transfer; read data lands in rd.
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] w);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wait_n(input int n);
    repeat (n) @(negedge hclk);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Reset hold, power-on wait and register map.
  task test_reset;
    chk(status_oe, 1);
    chk(hresp, 0);
    bus(0, STATUS_ADDR, 0);
    chk(32'(rd[2:0]), 32'(ST_HOLD));
    supply_valid <= 1'b1;
    wait_n(10);
    bus(0, STATUS_ADDR, 0);
    chk(32'(rd[2:0]), 32'(ST_IDLE));
    chk(32'(rd[ST_READY_BIT]), 1);
    bus(0, CONTROL_ADDR, 0);
    chk(32'(rd[1:0]), 32'(CONTROL_RESET));
    bus(0, 32'h8, 0);
    chk(rd, 0);
  endtask
  // Each switch alone must release the status line after the debounce time.
  task test_debounce(input logic low_side);
    int n;
    @(posedge hclk);
    insert_low <= low_side;
    insert_high <= !low_side;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (status_oe !== 1'b0 && n < 100);
    chk(32'(n >= DEB && n <= DEB + 4), 1);
  endtask
  // A disabled block refuses, then a full 5V activation and all divider codes.
  task automatic test_activation;
    int t, first, n;
    logic [1:0] sel_tab [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    int div_tab [4] = '{8, 4, 2, 1};
    bus(1, CONTROL_ADDR, 0);
    req_n <= 1'b0;
    wait_n(10);
    chk(osc_fast, 0);
    @(posedge hclk);
    req_n <= 1'b1;
    bus(1, CONTROL_ADDR, 1);
    vsel <= 1'b1;
    @(posedge hclk);
    req_n <= 1'b0;
    wait_n(3);
    chk(osc_fast, 1);
    chk(32'(card_vcc_level), 32'(VCC_5V));
    wait_n(9900);
    chk(data_en, 0);
    wait_n(200);
    chk(data_en, 1);
    wait_n(7300);
    chk(card_reset, 0);
    wait_n(200);
    chk(card_reset, 1);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      {div_a, div_b} <= sel_tab[i];
      wait_n(100);
      t = 0;
      n = 0;
      first = 0;
      prev = card_clock;
      repeat (200) begin
        @(negedge hclk);
        t++;
        if (card_clock === 1'b1 && prev === 1'b0) begin
          if (n == 1) chk(t - first, 6 * div_tab[i]);
          first = t;
          n++;
        end
        prev = card_clock;
      end
    end
  endtask
  // Session end steps the contacts down in order.
  task test_deactivation;
    @(posedge hclk);
    req_n <= 1'b1;
    wait_n(2);
    chk(card_reset, 0);
    // Clock register clears one cycle after 0.5T.
    wait_n(HALF_T_CYCLES + 1);
    repeat (6) begin
      @(negedge hclk);
      chk(card_clock, 0);
    end
    wait_n(HALF_T_CYCLES - 9);
    chk(data_en, 1);
    wait_n(2);
    chk(data_en, 0);
    wait_n(HALF_T_CYCLES - 2);
    chk(vcc_en, 1);
    wait_n(2);
    chk(vcc_en, 0);
    wait_n(HALF_T_CYCLES + 2);
  endtask
  // Supply level for the select pairs 00, 01 and 11, then stop mode.
  task automatic test_voltage;
    logic [1:0] vs_tab [3] = '{2'b00, 2'b01, 2'b11};
    logic [1:0] lvl_tab [3] = '{VCC_3V, VCC_1V8, VCC_1V8};
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk);
      {vsel, lvsel} <= vs_tab[i];
      @(posedge hclk);
      req_n <= 1'b0;
      wait_n(3);
      chk(32'(card_vcc_level), 32'(lvl_tab[i]));
      @(posedge hclk);
      req_n <= 1'b1;
      wait_n(4 * HALF_T_CYCLES + 4);
    end
    chk(stop_mode, 1);
    @(posedge hclk);
    lvsel <= 1'b0;
    wait_n(3);
    chk(stop_mode, 0);
  endtask
  // Supply loss early in activation powers the card down and holds the block.
  task test_supply_drop;
    @(posedge hclk);
    req_n <= 1'b0;
    wait_n(20);
    @(posedge hclk);
    supply_valid <= 1'b0;
    wait_n(3 * HALF_T_CYCLES + 4);
    chk(vcc_en, 0);
    wait_n(HALF_T_CYCLES + 2);
    bus(0, STATUS_ADDR, 0);
    chk(32'(rd[2:0]), 32'(ST_HOLD));
  endtask
  ////////////////////////////////////////////////////////////
  // Cuts a hang short.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_debounce(1'b1);
    @(posedge hclk);
    insert_low <= 1'b0;
    wait_n(40);
    test_debounce(1'b0);
    test_activation();
    test_deactivation();
    test_voltage();
    test_supply_drop();
    tally_and_finish();
  end
endmodule
